/* File: pkg/pinfunc_pkg.sv */
package pinfunc_pkg;

  // ---------------------------------------------------------------
  // Bus geometry
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned PIN_N  = 8;
  localparam int unsigned LCD_N  = 4;

  // ---------------------------------------------------------------
  // Register indices and byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0]        LOW_MODES_IDX  = 8'hA4;
  localparam logic [7:0]        HIGH_MODES_IDX = 8'hA5;
  localparam logic [7:0]        TOC_IDX        = 8'hA6;
  localparam logic [ADDR_W-1:0] LOW_MODES_ADDR  = {2'h0, LOW_MODES_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] HIGH_MODES_ADDR = {2'h0, HIGH_MODES_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] TOC_ADDR        = {2'h0, TOC_IDX, 2'h0};

  // ---------------------------------------------------------------
  // Reset values and field layout
  // ---------------------------------------------------------------
  localparam logic [7:0] LOW_MODES_RST  = 8'hFF;
  localparam logic [7:0] HIGH_MODES_RST = 8'h00;
  localparam logic [7:0] TOC_RST        = 8'h00;
  localparam int unsigned MODE_W  = 2;
  localparam logic [1:0]  MODE_ALT = 2'h3;
  localparam int unsigned T1_SEL_LSB  = 6;
  localparam int unsigned T2_SEL_LSB  = 3;
  localparam int unsigned SYS_SEL_LSB = 0;
  localparam int unsigned TOUCH_PIN   = 4;
  localparam int unsigned T1_CLK_PIN  = 5;
  localparam int unsigned T1_COMP_PIN = 6;
  localparam int unsigned SYSO_PIN    = 7;

  // ---------------------------------------------------------------
  // Divider codes, periods and high counts
  // ---------------------------------------------------------------
  localparam logic [2:0] DIV_HALF           = 3'h0;
  localparam logic [2:0] DIV_THIRD          = 3'h1;
  localparam logic [2:0] DIV_QUARTER        = 3'h2;
  localparam logic [2:0] DIV_TWO_THIRDS     = 3'h5;
  localparam logic [2:0] DIV_THREE_QUARTERS = 3'h6;
  localparam logic [2:0] PERIOD_2 = 3'h2;
  localparam logic [2:0] PERIOD_3 = 3'h3;
  localparam logic [2:0] PERIOD_4 = 3'h4;
  localparam logic [2:0] HIGH_1   = 3'h1;
  localparam logic [2:0] HIGH_2   = 3'h2;
  localparam logic [2:0] HIGH_3   = 3'h3;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic              pready;
    logic [DATA_W-1:0] prdata;
    logic              pslverr;
  } apb_rsp_t;

endpackage : pinfunc_pkg

/* File: design/overflow_divider.sv */
`timescale 1ns/10ps
module overflow_divider
  import pinfunc_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       tick_i,
  input  wire logic [2:0] code_i,
  output logic            out_o
);

  typedef struct packed {
    logic [2:0] cnt;
    logic       out;
  } div_state_t;

  div_state_t st;
  div_state_t next_st;
  logic [2:0] period;
  logic [2:0] high;
  logic [2:0] cnt_inc;

  always_comb begin
    next_st = st;
    cnt_inc = 3'(st.cnt + 3'h1);
    // RULE8 RULE9 duty decode.
    case (code_i)
      DIV_THIRD: begin
        period = PERIOD_3;
        high   = HIGH_1;
      end
      DIV_QUARTER: begin
        period = PERIOD_4;
        high   = HIGH_1;
      end
      DIV_TWO_THIRDS: begin
        period = PERIOD_3;
        high   = HIGH_2;
      end
      DIV_THREE_QUARTERS: begin
        period = PERIOD_4;
        high   = HIGH_3;
      end
      // RULE10 half fallback.
      default: begin
        period = PERIOD_2;
        high   = HIGH_1;
      end
    endcase
    // RULE10 count overflow events.
    if (tick_i) begin
      next_st.cnt = (cnt_inc >= period) ? 3'h0 : cnt_inc;
      next_st.out = (next_st.cnt < high);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign out_o = st.out;

  sequence s_wrap;
    tick_i && $stable(code_i) && (cnt_inc >= period);
  endsequence

  // RULE10 high after wrap.
  a_wrap_goes_high: assert property (@(posedge clk_i) disable iff (rst_i) // RULE10
    s_wrap |=> st.cnt == 3'h0 && st.out)
    else $error("Divider did not restart high after wrap.");

  // RULE10 hold between events.
  a_hold_no_tick: assert property (@(posedge clk_i) disable iff (rst_i) // RULE10
    !tick_i |=> $stable(st.out) && $stable(st.cnt))
    else $error("Divider output moved without an event.");

endmodule : overflow_divider

/* File: design/pin_route.sv */
`timescale 1ns/10ps
module pin_route
  import pinfunc_pkg::*;
(
  input  wire logic [1:0] mode_i,
  input  wire logic       port_out_i,
  input  wire logic       port_oe_i,
  input  wire logic       alt_out_i,
  input  wire logic       alt_oe_i,
  output logic            out_o,
  output logic            oe_o
);

  // RULE1 mode three selects alternate.
  always_comb begin
    out_o = (mode_i == MODE_ALT) ? alt_out_i : port_out_i;
    oe_o  = (mode_i == MODE_ALT) ? alt_oe_i : port_oe_i;
  end

endmodule : pin_route

/* File: design/port3_pinfunc.sv */
// How it works
// RULE1: Each port-3 pin has a two-bit mode field; four fields per register.
// RULE2: Pins 0 to 3 reset to mode 3 and then drive LCD segments.
// RULE3: Pins 4 to 7 reset to mode 0; pin 7 mode 3 outputs divided clock.
// RULE4: Pin 6 mode 3 drives the timer 1 complementary output.
// RULE5: Pin 5 mode 3 drives the timer 1 divided overflow clock.
// RULE6: Pin 4 mode 3 connects to touch-key charge collection.
// RULE7: Timer 1 output field bits 7:6 resets zero; selects half, third, quarter.
// RULE8: Timer 2 output field bits 5:3 resets zero; selects half, third, quarter.
// RULE9: Timer 2 codes 101 and 110 give two-thirds and three-quarter duty.
// RULE10: Duty counts overflow events high; unknown codes give half duty, half rate.
//
// Added by the designer: the APB register port.
`timescale 1ns/10ps
module port3_pinfunc
  import pinfunc_pkg::*;
(
  input  wire logic                    CLK_I,
  input  wire logic                    RST_I,
  input  wire pinfunc_pkg::apb_req_t   APB_I,
  output pinfunc_pkg::apb_rsp_t        APB_O,
  input  wire logic [7:0]              PIN_I,
  output logic [7:0]                   PIN_O,
  output logic [7:0]                   PIN_OE_O,
  input  wire logic [7:0]              PORT_OUT_I,
  input  wire logic [7:0]              PORT_OE_I,
  output logic [7:0]                   PORT_IN_O,
  output logic [15:0]                  PIN_MODES_O,
  input  wire logic [3:0]              LCD_SEG_I,
  input  wire logic                    TOUCH_OUT_I,
  input  wire logic                    TOUCH_OE_I,
  output logic                         TOUCH_IN_O,
  input  wire logic                    TIMER1_OVF_I,
  input  wire logic                    TIMER2_OVF_I,
  output logic                         TIMER1_CLK_O,
  output logic                         TIMER2_CLK_O
);

  import pinfunc_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0]        low_modes;
    logic [7:0]        high_modes;
    logic [7:0]        toc;
    logic [7:0]        sync1;
    logic [7:0]        sync2;
    logic [7:0]        pin_out;
    logic [7:0]        pin_oe;
    logic [DATA_W-1:0] prdata;
    logic              slverr;
  } top_state_t;

  top_state_t        st;
  top_state_t        next_st;
  logic [15:0]       modes;
  logic [7:0]        alt_out;
  logic [7:0]        alt_oe;
  logic [7:0]        route_out;
  logic [7:0]        route_oe;
  logic              t1_clk;
  logic              t2_clk;
  logic              sys_clk_div;
  logic              setup;
  logic              access;
  logic              hit_low;
  logic              hit_high;
  logic              hit_toc;

  assign modes = {st.high_modes, st.low_modes};

  // ---------------------------------------------------------------
  // Output dividers
  // ---------------------------------------------------------------
  // RULE7 timer 1 duty select.
  overflow_divider u_timer1_div (
    .clk_i  (CLK_I),
    .rst_i  (RST_I),
    .tick_i (TIMER1_OVF_I),
    .code_i ({1'b0, st.toc[T1_SEL_LSB +: 2]}),
    .out_o  (t1_clk)
  );

  // RULE8 timer 2 duty select.
  overflow_divider u_timer2_div (
    .clk_i  (CLK_I),
    .rst_i  (RST_I),
    .tick_i (TIMER2_OVF_I),
    .code_i (st.toc[T2_SEL_LSB +: 3]),
    .out_o  (t2_clk)
  );

  overflow_divider u_sysclk_div (
    .clk_i  (CLK_I),
    .rst_i  (RST_I),
    .tick_i (1'b1),
    .code_i (st.toc[SYS_SEL_LSB +: 3]),
    .out_o  (sys_clk_div)
  );

  // ---------------------------------------------------------------
  // Alternate functions
  // ---------------------------------------------------------------
  always_comb begin
    alt_out = '0;
    alt_oe  = '0;
    // RULE2 LCD segment drive.
    alt_out[LCD_N-1:0] = LCD_SEG_I;
    alt_oe[LCD_N-1:0]  = '1;
    // RULE6 touch charge collect.
    alt_out[TOUCH_PIN] = TOUCH_OUT_I;
    alt_oe[TOUCH_PIN]  = TOUCH_OE_I;
    // RULE5 timer 1 clock.
    alt_out[T1_CLK_PIN]  = t1_clk;
    alt_oe[T1_CLK_PIN]   = 1'b1;
    // RULE4 timer 1 complement.
    alt_out[T1_COMP_PIN] = ~t1_clk;
    alt_oe[T1_COMP_PIN]  = 1'b1;
    // RULE3 divided system clock.
    alt_out[SYSO_PIN] = sys_clk_div;
    alt_oe[SYSO_PIN]  = 1'b1;
  end

  genvar k;
  generate
    for (k = 0; k < PIN_N; k++) begin : g_pin
      pin_route u_route (
        .mode_i     (modes[MODE_W*k +: MODE_W]),
        .port_out_i (PORT_OUT_I[k]),
        .port_oe_i  (PORT_OE_I[k]),
        .alt_out_i  (alt_out[k]),
        .alt_oe_i   (alt_oe[k]),
        .out_o      (route_out[k]),
        .oe_o       (route_oe[k])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Register bus
  // ---------------------------------------------------------------
  assign setup    = APB_I.psel && !APB_I.penable;
  assign access   = APB_I.psel && APB_I.penable;
  assign hit_low  = (APB_I.paddr == LOW_MODES_ADDR);
  assign hit_high = (APB_I.paddr == HIGH_MODES_ADDR);
  assign hit_toc  = (APB_I.paddr == TOC_ADDR);

  always_comb begin
    next_st         = st;
    next_st.sync1   = PIN_I;
    next_st.sync2   = st.sync1;
    next_st.pin_out = route_out;
    next_st.pin_oe  = route_oe;
    if (setup) begin
      next_st.slverr = !(hit_low || hit_high || hit_toc);
      next_st.prdata = '0;
      if (hit_low) begin
        next_st.prdata[7:0] = st.low_modes;
      end else if (hit_high) begin
        next_st.prdata[7:0] = st.high_modes;
      end else if (hit_toc) begin
        next_st.prdata[7:0] = st.toc;
      end
    end
    // RULE1 field write.
    if (access && APB_I.pwrite) begin
      if (hit_low) begin
        next_st.low_modes = APB_I.pwdata[7:0];
      end
      if (hit_high) begin
        next_st.high_modes = APB_I.pwdata[7:0];
      end
      if (hit_toc) begin
        next_st.toc = APB_I.pwdata[7:0];
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      st            <= '0;
      // RULE2 low modes reset.
      st.low_modes  <= LOW_MODES_RST;
      // RULE3 high modes reset.
      st.high_modes <= HIGH_MODES_RST;
      // RULE7 RULE8 control reset.
      st.toc        <= TOC_RST;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign APB_O.pready  = 1'b1;
  assign APB_O.prdata  = st.prdata;
  assign APB_O.pslverr = access && st.slverr;
  assign PIN_O         = st.pin_out;
  assign PIN_OE_O      = st.pin_oe;
  assign PORT_IN_O     = st.sync2;
  assign PIN_MODES_O   = modes;
  assign TOUCH_IN_O    = (modes[MODE_W*TOUCH_PIN +: MODE_W] == MODE_ALT) && st.sync2[TOUCH_PIN];
  assign TIMER1_CLK_O  = t1_clk;
  assign TIMER2_CLK_O  = t2_clk;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_low_write;
    access && APB_I.pwrite && hit_low;
  endsequence

  sequence s_setup_low;
    setup && hit_low;
  endsequence

  // RULE1 write reaches field.
  a_low_field_write: assert property (@(posedge CLK_I) disable iff (RST_I) // RULE1
    s_low_write |=> st.low_modes == $past(APB_I.pwdata[7:0]))
    else $error("Low mode register missed a write.");

  // RULE1 readback of fields.
  a_low_read_back: assert property (@(posedge CLK_I) disable iff (RST_I) // RULE1
    s_setup_low ##1 access |-> APB_O.prdata == {24'h000000, st.low_modes})
    else $error("Low mode register read back wrong.");

  // RULE2 RULE3 reset values.
  a_reset_values: assert property (@(posedge CLK_I) // RULE3
    RST_I |=> st.low_modes == LOW_MODES_RST && st.high_modes == HIGH_MODES_RST && st.toc == TOC_RST)
    else $error("Mode registers wrong after reset.");

  // RULE2 LCD drive path.
  a_lcd_seg_route: assert property (@(posedge CLK_I) disable iff (RST_I) // RULE2
    modes[MODE_W-1:0] == MODE_ALT |=> PIN_O[0] == $past(LCD_SEG_I[0]) && PIN_OE_O[0])
    else $error("Pin 0 does not carry the LCD segment.");

  // RULE3 divided clock path.
  a_sysclk_route: assert property (@(posedge CLK_I) disable iff (RST_I) // RULE3
    modes[MODE_W*SYSO_PIN +: MODE_W] == MODE_ALT |=> PIN_O[SYSO_PIN] == $past(sys_clk_div))
    else $error("Pin 7 does not carry the divided clock.");

  // RULE4 complement path.
  a_t1_comp_route: assert property (@(posedge CLK_I) disable iff (RST_I) // RULE4
    modes[MODE_W*T1_COMP_PIN +: MODE_W] == MODE_ALT |=> PIN_O[T1_COMP_PIN] == !$past(t1_clk))
    else $error("Pin 6 does not carry the timer 1 complement.");

  // RULE5 timer 1 path.
  a_t1_clk_route: assert property (@(posedge CLK_I) disable iff (RST_I) // RULE5
    modes[MODE_W*T1_CLK_PIN +: MODE_W] == MODE_ALT |=> PIN_O[T1_CLK_PIN] == $past(t1_clk))
    else $error("Pin 5 does not carry the timer 1 clock.");

  // RULE6 touch connection.
  a_touch_route: assert property (@(posedge CLK_I) disable iff (RST_I) // RULE6
    modes[MODE_W*TOUCH_PIN +: MODE_W] == MODE_ALT |=>
      PIN_OE_O[TOUCH_PIN] == $past(TOUCH_OE_I) && PIN_O[TOUCH_PIN] == $past(TOUCH_OUT_I))
    else $error("Pin 4 does not follow the touch charge drive.");

endmodule : port3_pinfunc

/* File: testbench/test_port3_pinfunc.sv */
`timescale 1ns/10ps
module test_port3_pinfunc;
  import pinfunc_pkg::*;

  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic        clk;
  logic        rst;
  apb_req_t    req;
  apb_rsp_t    rsp;
  logic [7:0]  pin_in, pin_out, pin_oe, port_out, port_oe, port_in, lo, hm;
  logic [15:0] modes;
  logic [3:0]  lcd;
  logic        touch_out, touch_oe, touch_in, ovf1, ovf2, t1clk, t2clk, err;
  logic [31:0] rd;
  int          errors, n_checks, seed;

  always #2 clk = ~clk;

  port3_pinfunc u_port3_pinfunc (
    .CLK_I(clk), .RST_I(rst), .APB_I(req), .APB_O(rsp), .PIN_I(pin_in), .PIN_O(pin_out),
    .PIN_OE_O(pin_oe), .PORT_OUT_I(port_out), .PORT_OE_I(port_oe), .PORT_IN_O(port_in),
    .PIN_MODES_O(modes), .LCD_SEG_I(lcd), .TOUCH_OUT_I(touch_out), .TOUCH_OE_I(touch_oe),
    .TOUCH_IN_O(touch_in), .TIMER1_OVF_I(ovf1), .TIMER2_OVF_I(ovf2), .TIMER1_CLK_O(t1clk),
    .TIMER2_CLK_O(t2clk)
  );

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk);
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite  <= wr;
    req.paddr   <= a;
    req.pwdata  <= wd;
    @(posedge clk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 50);
    chk("pready", 32'h1, {31'h0, rsp.pready});
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle

  task automatic step(input int which);
    @(posedge clk);
    ovf1 <= (which == 1);
    ovf2 <= (which == 2);
    if (which != 0) begin
      @(posedge clk);
      ovf1 <= 1'b0;
      ovf2 <= 1'b0;
    end
    #1;
  endtask : step

  function automatic int per(input logic [2:0] c);
    return (c == 3'h1 || c == 3'h5) ? 3 : (c == 3'h2 || c == 3'h6) ? 4 : 2;
  endfunction : per

  function automatic int high(input logic [2:0] c);
    return (c == 3'h5) ? 2 : (c == 3'h6) ? 3 : 1;
  endfunction : high

  function automatic logic sel(input int which);
    return (which == 1) ? t1clk : (which == 2) ? t2clk : pin_out[7];
  endfunction : sel

  task automatic measure(input int which, input logic [2:0] c);
    int   hi, rises;
    logic prev, s;
    if (which == 1) apb(1'b1, TOC_ADDR, {24'h0, c[1:0], 6'h0});
    if (which == 2) apb(1'b1, TOC_ADDR, {26'h0, c, 3'h0});
    if (which == 0) apb(1'b1, TOC_ADDR, {29'h0, c});
    repeat (4) step(which);
    prev = sel(which);
    hi = 0;
    rises = 0;
    repeat (12) begin
      step(which);
      s = sel(which);
      hi += s;
      rises += (s && !prev);
      prev = s;
    end
    chk("high count", 32'(12 * high(c) / per(c)), 32'(hi));
    chk("rising edges", 32'(12 / per(c)), 32'(rises));
  endtask : measure

  function automatic logic [15:0] exp_pins(input logic [15:0] m);
    logic [7:0] o, e;
    for (int k = 0; k < 8; k++) begin
      o[k] = port_out[k];
      e[k] = port_oe[k];
      if (m[2*k +: 2] == 2'h3 && k < 4) begin
        o[k] = lcd[k];
        e[k] = 1'b1;
      end
      if (m[2*k +: 2] == 2'h3 && k == 4) begin
        o[k] = touch_out;
        e[k] = touch_oe;
      end
    end
    return {e, o};
  endfunction : exp_pins

  task final_report;
    if (errors == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report

  // ---------------------------------------------------------------
  // Watchdog
  // ---------------------------------------------------------------
  initial begin
    #200000;
    errors++;
    final_report();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    seed = 33;
    clk = 1'b0;
    rst = 1'b1;
    req = '0;
    ovf1 = 1'b0;
    ovf2 = 1'b0;
    pin_in = 8'($random(seed));
    port_out = 8'($random(seed));
    port_oe = 8'($random(seed));
    lcd = 4'($random(seed));
    touch_out = 1'b1;
    touch_oe = 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, LOW_MODES_ADDR, 32'h0);
    chk("low modes reset", 32'h0000_00FF, rd);
    apb(1'b0, HIGH_MODES_ADDR, 32'h0);
    chk("high modes reset", 32'h0000_0000, rd);
    apb(1'b0, TOC_ADDR, 32'h0);
    chk("control reset", 32'h0000_0000, rd);
    chk("control error", 32'h0, {31'h0, err});
    chk("lcd pins reset", {24'h0, 4'hF, lcd}, {24'h0, pin_oe[3:0], pin_out[3:0]});
    apb(1'b1, HIGH_MODES_ADDR, 32'h0000_003C);
    for (int j = 0; j < 4; j++) begin
      if (j > 0) step(1);
      settle(2);
      chk("timer1 clock", {31'h0, j > 0 && j % 2 == 0}, {31'h0, t1clk});
      chk("pin5", {31'h0, j > 0 && j % 2 == 0}, {31'h0, pin_out[5]});
      chk("pin6", {31'h0, !(j > 0 && j % 2 == 0)}, {31'h0, pin_out[6]});
    end
    for (int i = 0; i < 10; i++) begin
      lo = (i == 1) ? 8'h00 : 8'($random(seed));
      hm = (i == 2) ? 8'h03 : 8'($random(seed)) & 8'h57;
      @(posedge clk);
      port_out <= 8'($random(seed));
      port_oe <= 8'($random(seed));
      lcd <= 4'($random(seed));
      touch_out <= 1'($random(seed));
      touch_oe <= 1'($random(seed));
      pin_in <= 8'($random(seed));
      apb(1'b1, LOW_MODES_ADDR, {24'($random(seed)), lo});
      apb(1'b1, HIGH_MODES_ADDR, {24'($random(seed)), hm});
      apb(1'b0, LOW_MODES_ADDR, 32'h0);
      chk("low modes", {24'h0, lo}, rd);
      apb(1'b0, HIGH_MODES_ADDR, 32'h0);
      chk("high modes", {24'h0, hm}, rd);
      settle(4);
      chk("mode vector", {16'h0, hm, lo}, {16'h0, modes});
      chk("pin drive", {16'h0, exp_pins({hm, lo})}, {16'h0, pin_oe, pin_out});
      chk("port input", {24'h0, pin_in}, {24'h0, port_in});
      chk("touch input", {31'h0, hm[1:0] == 2'h3 && pin_in[4]}, {31'h0, touch_in});
    end
    apb(1'b1, 12'h29C, 32'h0000_00FF);
    chk("unmapped write error", 32'h1, {31'h0, err});
    apb(1'b0, 12'h29C, 32'h0);
    chk("unmapped read", 32'h0000_0000, rd);
    apb(1'b0, HIGH_MODES_ADDR, 32'h0);
    chk("high modes kept", {24'h0, hm}, rd);
    for (int c = 0; c < 3; c++) measure(1, 3'(c));
    measure(1, 3'h3);
    for (int c = 0; c < 3; c++) measure(2, 3'(c));
    measure(2, 3'h5);
    measure(2, 3'h6);
    measure(2, 3'h3);
    measure(2, 3'h4);
    measure(2, 3'h7);
    // divided system clock on pin 7.
    apb(1'b1, HIGH_MODES_ADDR, 32'h0000_00C0);
    for (int c = 0; c < 3; c++) measure(0, 3'(c));
    measure(0, 3'h5);
    measure(0, 3'h6);
    final_report();
  end

endmodule : test_port3_pinfunc
